// >>> verilog/etc_pkg.sv
package etc_pkg;

  // ------------------------------------------------------------
  // counter geometry
  // ------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam int PRD_W = 3;
  localparam int REG_W = 8;
  localparam int BUS_W = 32;
  localparam int ADR_W = 8;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL0 = 8'h00;
  localparam logic [7:0] ADR_CTRL1 = 8'h04;
  localparam logic [7:0] ADR_CTRL2 = 8'h08;
  localparam logic [7:0] ADR_CNT_LO = 8'h0c;
  localparam logic [7:0] ADR_CNT_HI = 8'h10;
  localparam logic [7:0] ADR_CMPA_LO = 8'h14;
  localparam logic [7:0] ADR_CMPA_HI = 8'h18;
  localparam logic [7:0] ADR_CMPB_LO = 8'h1c;
  localparam logic [7:0] ADR_CMPB_HI = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int C0_PAUSE = 7;
  localparam int C0_CKSEL_HI = 6;
  localparam int C0_CKSEL_LO = 4;
  localparam int C0_RUN = 3;
  localparam int C0_PRD_HI = 2;
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_IO_HI = 5;
  localparam int C1_IO_LO = 4;
  localparam int C1_INIT_LVL = 3;
  localparam int C1_DOWN = 1;
  localparam int C1_CLR_SRC = 0;
  localparam int ST_DIR = 0;
  localparam int ST_FLAG_A = 1;
  localparam int ST_FLAG_B = 2;
  localparam int ST_FLAG_P = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [9:0] CNT_RST = 10'h000;

  // ------------------------------------------------------------
  // encodings and divider counts
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'h0, CK_SYS = 3'h1, CK_SLOW_16 = 3'h2, CK_SLOW_64 = 3'h3,
    CK_TIMEBASE = 3'h4, CK_UNDEF = 3'h5, CK_EXT_RISE = 3'h6, CK_EXT_FALL = 3'h7
  } etc_clk_sel_type;
  localparam logic [1:0] MODE_CMP_OUT = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [5:0] SYS_DIV = 6'h04;
  // seven bits so that the /64 count itself fits without wrapping to zero
  localparam logic [6:0] SLOW_DIV_A = 7'h10;
  localparam logic [6:0] SLOW_DIV_B = 7'h40;

endpackage

// >>> verilog/etc_pin_edge.sv
`timescale 1ns/1ns
// two-flop synchroniser on the external count pin with edge pulses
module etc_pin_edge (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // ------------------------------------------------------------
  // synchroniser; meta_q feeds only sync_q
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // one pulse per edge, seen one to two cycles after the pin moves
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule

// >>> verilog/etc_clk_sel.sv
`timescale 1ns/1ns
// count clock selection, every rate is a one-cycle enable
module etc_clk_sel (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] sel_i,
  input wire logic slow_tick_i,
  input wire logic timebase_tick_i,
  input wire logic ext_rise_i,
  input wire logic ext_fall_i,
  output logic tick_o
);
  logic [5:0] sys_cnt_q;
  logic [5:0] slow_cnt_q;
  logic sys4;
  logic slow16;
  logic slow64;

  // ------------------------------------------------------------
  // dividers; the slow divider free-runs so /16 and /64 share it
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_cnt_q <= 6'h00;
    end else if (sys_cnt_q == etc_pkg::SYS_DIV - 6'h01) begin
      sys_cnt_q <= 6'h00;
    end else begin
      sys_cnt_q <= sys_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slow_cnt_q <= 6'h00;
    end else if (slow_tick_i) begin
      slow_cnt_q <= slow_cnt_q + 6'h01; // wraps at 64
    end
  end

  assign sys4 = (sys_cnt_q == etc_pkg::SYS_DIV - 6'h01);
  assign slow16 = slow_tick_i & (slow_cnt_q[3:0] == 4'(etc_pkg::SLOW_DIV_A - 7'h01));
  assign slow64 = slow_tick_i & (slow_cnt_q == 6'(etc_pkg::SLOW_DIV_B - 7'h01));

  // source mux; the undefined code gives no tick at all
  always_comb begin
    case (etc_pkg::etc_clk_sel_type'(sel_i))
      etc_pkg::CK_SYS_DIV4: tick_o = sys4;
      etc_pkg::CK_SYS: tick_o = 1'b1;
      etc_pkg::CK_SLOW_16: tick_o = slow16;
      etc_pkg::CK_SLOW_64: tick_o = slow64;
      etc_pkg::CK_TIMEBASE: tick_o = timebase_tick_i;
      etc_pkg::CK_EXT_RISE: tick_o = ext_rise_i;
      etc_pkg::CK_EXT_FALL: tick_o = ext_fall_i;
      default: tick_o = 1'b0;
    endcase
  end
endmodule

// >>> verilog/etc_core.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// ------------------------------------------------------------
module etc_core (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_count_pin_i,
  input wire logic slow_clk_tick_i,
  input wire logic timebase_clock_tick_i,
  output logic timer_output_a_o,
  output logic irq_a_o,
  output logic irq_b_o,
  output logic irq_p_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [9:0] cnt_q;
  logic [9:0] cmp_a_q;
  logic [9:0] cmp_b_q;
  logic count_down_q;
  logic flag_a_q;
  logic flag_b_q;
  logic flag_p_q;
  logic run_last_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic out_a_q;
  logic irq_a_q;
  logic irq_b_q;
  logic irq_p_q;

  // ------------------------------------------------------------
  // decoded control fields
  // ------------------------------------------------------------
  logic count_pause;
  logic [2:0] count_clock_select;
  logic timer_run;
  logic [2:0] period_field;
  logic clear_source_select;
  logic output_initial_level;
  logic [1:0] mode_field;
  logic [1:0] io_field;

  assign count_pause = ctrl0_q[etc_pkg::C0_PAUSE];
  assign count_clock_select = ctrl0_q[etc_pkg::C0_CKSEL_HI:etc_pkg::C0_CKSEL_LO];
  assign timer_run = ctrl0_q[etc_pkg::C0_RUN];
  assign period_field = ctrl0_q[etc_pkg::C0_PRD_HI:0];
  assign clear_source_select = ctrl1_q[etc_pkg::C1_CLR_SRC];
  assign output_initial_level = ctrl1_q[etc_pkg::C1_INIT_LVL];
  assign mode_field = ctrl1_q[etc_pkg::C1_MODE_HI:etc_pkg::C1_MODE_LO];
  assign io_field = ctrl1_q[etc_pkg::C1_IO_HI:etc_pkg::C1_IO_LO];

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic req;
  logic wr_take;
  logic wr_lane;

  // a write takes effect on the edge that the master sees ack high
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_take = req & wb_we_i & ack_q;
  assign wr_lane = wr_take & wb_sel_i[0];

  function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] target);
    wr_hit = (adr == target);
  endfunction

  // ------------------------------------------------------------
  // count clock source and pin edges
  // ------------------------------------------------------------
  logic ext_rise;
  logic ext_fall;
  logic src_tick;

  etc_pin_edge u_pin (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_count_pin_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  etc_clk_sel u_clk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sel_i(count_clock_select),
    .slow_tick_i(slow_clk_tick_i),
    .timebase_tick_i(timebase_clock_tick_i),
    .ext_rise_i(ext_rise),
    .ext_fall_i(ext_fall),
    .tick_o(src_tick)
  );

  // ------------------------------------------------------------
  // counter step and comparators
  // ------------------------------------------------------------
  logic run_rise;
  logic step;
  logic [9:0] cnt_next;
  logic wrap;
  logic hit_a;
  logic hit_b;
  logic hit_p;
  logic clr_a;
  logic clr_p;

  // run rise seen in the same cycle that the write lands in ctrl0_q
  assign run_rise = timer_run & ~run_last_q;
  // pause and run both gate the tick, and so does the run rise cycle, which clears the count instead
  assign step = src_tick & timer_run & ~count_pause & ~run_rise;

  // step value in the chosen direction
  always_comb begin
    if (count_down_q) begin
      cnt_next = cnt_q - 10'h001;
    end else begin
      cnt_next = cnt_q + 10'h001;
    end
  end

  // wrap past the end of the range in either direction
  assign wrap = count_down_q ? (cnt_q == 10'h000) : (cnt_q == 10'h3ff);

  // A and B see all ten bits, P only the top three
  assign hit_a = step & (cnt_next == cmp_a_q);
  assign hit_b = step & (cnt_next == cmp_b_q);
  // nonzero period matches at 128 * field clocks; zero waits for the wrap
  assign hit_p = step & ((period_field == 3'h0) ? wrap : (cnt_next[9:7] == period_field));

  // clear source picks which comparator resets the count
  assign clr_a = hit_a & clear_source_select;
  assign clr_p = hit_p & ~clear_source_select;

  // ------------------------------------------------------------
  // counter; software has no load path at all
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= etc_pkg::CNT_RST;
    end else if (run_rise) begin
      cnt_q <= etc_pkg::CNT_RST;
    end else if (clr_a | clr_p) begin
      cnt_q <= etc_pkg::CNT_RST;
    end else if (step) begin
      cnt_q <= cnt_next; // wraps naturally on overflow
    end
  end

  // run edge tracker; a falling run leaves cnt_q alone
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_last_q <= 1'b0;
    end else begin
      run_last_q <= timer_run;
    end
  end

  // ------------------------------------------------------------
  // interrupt request pulses, registered so outputs come from flops
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      irq_p_q <= 1'b0;
    end else begin
      irq_a_q <= hit_a;
      irq_b_q <= hit_b;
      irq_p_q <= hit_p & ~clear_source_select; // no period request when A clears
    end
  end

  // ------------------------------------------------------------
  // sticky event flags, write one to clear; a new event wins
  // ------------------------------------------------------------
  logic st_wr;

  assign st_wr = wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_STATUS);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      flag_a_q <= hit_a | (flag_a_q & ~(st_wr & wb_dat_i[etc_pkg::ST_FLAG_A]));
      flag_b_q <= hit_b | (flag_b_q & ~(st_wr & wb_dat_i[etc_pkg::ST_FLAG_B]));
      flag_p_q <= (hit_p & ~clear_source_select) | (flag_p_q & ~(st_wr & wb_dat_i[etc_pkg::ST_FLAG_P]));
    end
  end

  // ------------------------------------------------------------
  // output pin a, compare match output mode only
  // ------------------------------------------------------------
  // the pin keeps its level in other modes; nothing else drives it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_a_q <= 1'b0;
    end else if (mode_field == etc_pkg::MODE_CMP_OUT) begin
      if (run_rise) begin
        out_a_q <= output_initial_level;
      end else if (hit_a) begin
        case (io_field)
          etc_pkg::IO_LOW: out_a_q <= 1'b0;
          etc_pkg::IO_HIGH: out_a_q <= 1'b1;
          etc_pkg::IO_TOGGLE: out_a_q <= ~out_a_q;
          default: out_a_q <= out_a_q;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl0_q <= etc_pkg::CTRL_RST;
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CTRL0)) begin
      ctrl0_q <= wb_dat_i[7:0];
    end
  end

  // direction bit of ctrl1 is status only, so its stored copy is masked
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_q <= etc_pkg::CTRL_RST;
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CTRL1)) begin
      ctrl1_q <= wb_dat_i[7:0] & ~(8'h01 << etc_pkg::C1_DOWN);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl2_q <= etc_pkg::CTRL_RST;
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CTRL2)) begin
      ctrl2_q <= wb_dat_i[7:0];
    end
  end

  // direction select, changed by software at any time
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_down_q <= 1'b0;
    end else if (st_wr) begin
      count_down_q <= wb_dat_i[etc_pkg::ST_DIR];
    end
  end

  // ------------------------------------------------------------
  // compare value pairs, low byte bits 7:0, high byte bits 9:8
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_a_q <= etc_pkg::CMP_RST;
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CMPA_LO)) begin
      cmp_a_q[7:0] <= wb_dat_i[7:0];
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CMPA_HI)) begin
      cmp_a_q[9:8] <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_b_q <= etc_pkg::CMP_RST;
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CMPB_LO)) begin
      cmp_b_q[7:0] <= wb_dat_i[7:0];
    end else if (wr_lane & wr_hit(wb_adr_i, etc_pkg::ADR_CMPB_HI)) begin
      cmp_b_q[9:8] <= wb_dat_i[1:0];
    end
  end

  // ------------------------------------------------------------
  // read mux; unmapped addresses read zero and still ack
  // ------------------------------------------------------------
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    case (wb_adr_i)
      etc_pkg::ADR_CTRL0: rmux[7:0] = ctrl0_q;
      etc_pkg::ADR_CTRL1: rmux[7:0] = ctrl1_q | (8'(count_down_q) << etc_pkg::C1_DOWN);
      etc_pkg::ADR_CTRL2: rmux[7:0] = ctrl2_q;
      etc_pkg::ADR_CNT_LO: rmux[7:0] = cnt_q[7:0];
      etc_pkg::ADR_CNT_HI: rmux[1:0] = cnt_q[9:8];
      etc_pkg::ADR_CMPA_LO: rmux[7:0] = cmp_a_q[7:0];
      etc_pkg::ADR_CMPA_HI: rmux[1:0] = cmp_a_q[9:8];
      etc_pkg::ADR_CMPB_LO: rmux[7:0] = cmp_b_q[7:0];
      etc_pkg::ADR_CMPB_HI: rmux[1:0] = cmp_b_q[9:8];
      etc_pkg::ADR_STATUS: rmux[3:0] = {flag_p_q, flag_b_q, flag_a_q, count_down_q};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // ack: one wait state, then drop for a cycle so back-to-back
  // requests never see a stale ack
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data captured with the ack so it stands while ack is high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req & ~ack_q & ~wb_we_i) begin
      rdat_q <= rmux;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign timer_output_a_o = out_a_q;
  assign irq_a_o = irq_a_q;
  assign irq_b_o = irq_b_q;
  assign irq_p_o = irq_p_q;

endmodule

// >>> verif/etc_core_monitor.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// port checker for the timer core
// ------------------------------------------------------------
module etc_core_mon (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_output_a_o,
  input wire logic irq_a_o,
  input wire logic irq_b_o,
  input wire logic irq_p_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] c0_q, c1_q;
  logic [1:0] halt_q, clr_q;
  logic wr_ok, halt;
  // shadow copies of the two control bytes, taken at the ack edge
  assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign halt = !c0_q[3] || c0_q[7] || c0_q[6:4] == 3'h5;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c0_q <= 8'h00;
      c1_q <= 8'h00;
    end else if (wr_ok && wb_adr_i == etc_pkg::ADR_CTRL0) begin
      c0_q <= wb_dat_i[7:0];
    end else if (wr_ok && wb_adr_i == etc_pkg::ADR_CTRL1) begin
      c1_q <= wb_dat_i[7:0];
    end
  end
  // saturating run lengths; three cycles cover the one-cycle irq lag
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      halt_q <= 2'h0;
      clr_q <= 2'h0;
    end else begin
      halt_q <= !halt ? 2'h0 : (halt_q == 2'h3 ? halt_q : halt_q + 2'h1);
      clr_q <= !c1_q[0] ? 2'h0 : (clr_q == 2'h3 ? clr_q : clr_q + 2'h1);
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_run_up;
    wr_ok && wb_adr_i == etc_pkg::ADR_CTRL0 && wb_dat_i[3] && !c0_q[3] && c1_q[7:6] == 2'h0;
  endsequence
  property p_ack_wait;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_rd_width;
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  property p_hi_bits;
    wb_ack_o && !wb_we_i && (wb_adr_i == etc_pkg::ADR_CNT_HI || wb_adr_i == etc_pkg::ADR_CMPA_HI)
      |-> wb_dat_o[7:2] == 6'h00;
  endproperty
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i > etc_pkg::ADR_STATUS |-> wb_dat_o == 32'h00000000;
  endproperty
  property p_halt_quiet;
    halt_q == 2'h3 |-> !(irq_a_o || irq_b_o || irq_p_o);
  endproperty
  property p_prd_mute;
    clr_q == 2'h3 |-> !irq_p_o;
  endproperty
  property p_prd_gap;
    irq_p_o |=> !irq_p_o [*8];
  endproperty
  property p_init_lvl;
    s_run_up |-> ##[1:2] timer_output_a_o == c1_q[3];
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_rd_width: assert property (p_rd_width) else $error("read upper bits set");
  a_hi_bits: assert property (p_hi_bits) else $error("high byte over two bits");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_halt_quiet: assert property (p_halt_quiet) else $error("irq while halted");
  a_prd_mute: assert property (p_prd_mute) else $error("period irq with clear on A");
  a_prd_gap: assert property (p_prd_gap) else $error("period irqs too close");
  a_init_lvl: assert property (p_init_lvl) else $error("output not restored");
endmodule

bind etc_core etc_core_mon i_etc_core_mon (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .timer_output_a_o(timer_output_a_o),
  .irq_a_o(irq_a_o),
  .irq_b_o(irq_b_o),
  .irq_p_o(irq_p_o)
);

// >>> verif/etc_far_model.sv
`timescale 1ns/1ns
// far side: count pin toggling every 4 cycles, slow and timebase ticks
module etc_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic pin_o,
  output logic slow_o,
  output logic tb_o
);
  logic [2:0] div_q;
  // pin edges of each kind every 8 cycles, timebase once in 8
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 3'h0;
      pin_o <= 1'b0;
      slow_o <= 1'b0;
      tb_o <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      slow_o <= !slow_o;
      tb_o <= div_q == 3'h6;
      if (div_q[1:0] == 2'h3) begin
        pin_o <= !pin_o;
      end
    end
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk, rst, cyc, stb, we, ack, out_a, irq_a, irq_b, irq_p, pin, slow, tbc;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, v;
  logic [2:0] irqs;
  int fail_count, tests_run, w;
  // counts expected after 1280 cycles for each clock select code
  int cnt_exp [8] = '{320, 256, 40, 10, 160, 0, 160, 160};
  assign irqs = {irq_p, irq_b, irq_a};
  always #50 clk = !clk;
  etc_core i_etc_core (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_count_pin_i(pin), .slow_clk_tick_i(slow), .timebase_clock_tick_i(tbc),
    .timer_output_a_o(out_a), .irq_a_o(irq_a), .irq_b_o(irq_b), .irq_p_o(irq_p));
  etc_far_model i_etc_far_model (.clk_i(clk), .rst_i(rst), .pin_o(pin), .slow_o(slow), .tb_o(tbc));
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  // waits for ack however long it takes; only the hang guard ends a stuck wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask
  // the high byte sits one word above the low byte
  task automatic rd10(input logic [7:0] a, output logic [31:0] q);
    logic [31:0] h;
    rd(a, q);
    rd(a + 8'h04, h);
    q = {h[23:0], q[7:0]};
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if (!(got >= lo && got <= hi)) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // bounded wait for the next pulse on one irq line
  task automatic wirq(input int k, output int n);
    n = 1;
    @(posedge clk);
    while (irqs[k] !== 1'b1 && n < 3000) begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic gap(input int k, input int exp);
    int n;
    wirq(k, n);
    wirq(k, n);
    chk(32'(n), 32'(exp));
  endtask
  task automatic restart(input logic [7:0] c);
    wr(etc_pkg::ADR_CTRL0, c & 8'hf7);
    wr(etc_pkg::ADR_CTRL0, c | 8'h08);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {clk, cyc, stb, we, adr, wdat} = '0;
    sel = 4'h1;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(8'(4 * i), v);
      chk(v, 32'h00000000);
    end
    wr(8'h30, 8'hff);
    rd(8'h30, v);
    chk(v, 32'h00000000);
    wr(etc_pkg::ADR_CMPA_LO, 8'ha5);
    wr(etc_pkg::ADR_CMPA_HI, 8'hff);
    rd10(etc_pkg::ADR_CMPA_LO, v);
    chk(v, 32'h000003a5);
    wr(etc_pkg::ADR_CNT_LO, 8'h55);
    sel <= 4'h0;
    wr(etc_pkg::ADR_CMPB_LO, 8'hff);
    sel <= 4'h1;
    rd10(etc_pkg::ADR_CNT_LO, v);
    chk(v, 32'h00000000);
    rd(etc_pkg::ADR_CMPB_LO, v);
    chk(v, 32'h00000000);
    $display("test registers done");
    // run rise clears, pause holds, stop keeps the residue
    restart(8'h10);
    wr(etc_pkg::ADR_CTRL0, 8'h98);
    rd10(etc_pkg::ADR_CNT_LO, v);
    chk(v, 32'h00000002);
    wr(etc_pkg::ADR_CTRL0, 8'h18);
    wr(etc_pkg::ADR_CTRL0, 8'h10);
    rd10(etc_pkg::ADR_CNT_LO, v);
    chk(v, 32'h00000005);
    $display("test pause done");
    // down count: direction reads back in ctrl1, count steps below zero
    wr(etc_pkg::ADR_STATUS, 8'h01);
    rd(etc_pkg::ADR_CTRL1, v);
    chk(v, 32'h00000002);
    restart(8'h11);
    repeat (10) @(posedge clk);
    wr(etc_pkg::ADR_CTRL0, 8'h11);
    rd10(etc_pkg::ADR_CNT_LO, v);
    chk_rng(v, 32'h000003f0, 32'h000003f8);
    wr(etc_pkg::ADR_STATUS, 8'h00);
    $display("test down count done");
    for (int p = 0; p < 8; p++) begin
      restart(8'h10 | 8'(p));
      gap(2, (p == 0) ? 1024 : 128 * p);
    end
    $display("test period done");
    for (int s = 0; s < 8; s++) begin
      restart({1'b0, 3'(s), 4'h0});
      repeat (1277) @(posedge clk);
      wr(etc_pkg::ADR_CTRL0, {1'b0, 3'(s), 4'h0});
      rd10(etc_pkg::ADR_CNT_LO, v);
      chk_rng(v, 32'(cnt_exp[s] - (s == 5 ? 0 : 2)), 32'(cnt_exp[s] + (s == 5 ? 0 : 2)));
    end
    $display("test clock select done");
    // toggle on A, initial level high, clear on A; B sits inside the A period
    wr(etc_pkg::ADR_CTRL1, 8'h39);
    wr(etc_pkg::ADR_CMPA_LO, 8'hf4);
    wr(etc_pkg::ADR_CMPA_HI, 8'h01);
    wr(etc_pkg::ADR_CMPB_LO, 8'hc8);
    restart(8'h10);
    gap(0, 500);
    gap(1, 500);
    restart(8'h10);
    repeat (3) @(posedge clk);
    chk({31'h0, out_a}, 32'h00000001);
    wirq(0, w);
    chk_rng(32'(w), 32'd490, 32'd500);
    repeat (3) @(posedge clk);
    chk({31'h0, out_a}, 32'h00000000);
    $display("test compare done");
    wrap_up();
  end
  // hang guard, well past the roughly 25000 cycles the tests need
  initial begin
    #(100 * 40000);
    fail_count++;
    wrap_up();
  end
endmodule
